// *** inc/bdsp_pkg.sv ***
/*
  Shared constants and types of the background debug serial port:
  word layout, response codes, command field positions and state records.
  Assumes a 40 MHz core clock and a host-driven serial clock.
*/
`default_nettype none

package bdsp_pkg;

  // ==========================================================
  // serial word layout
  localparam int WORD_BITS = 17;
  localparam int STATUS_POS = 16;
  localparam logic [4:0] BIT_COUNT_FULL = 5'h11;
  localparam logic [4:0] BIT_COUNT_DONE = 5'h00;

  // ==========================================================
  // device responses: status bit plus sixteen data bits
  localparam logic [16:0] RESP_COMPLETE = 17'h0FFFF;
  localparam logic [16:0] RESP_NOT_READY = 17'h10000;
  localparam logic [16:0] RESP_BUS_ERROR = 17'h10001;
  localparam logic [16:0] RESP_ILLEGAL = 17'h1FFFF;

  // ==========================================================
  // command word fields
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 10;
  localparam int DIR_POS = 7;
  localparam int SIZE_MSB = 5;
  localparam int SIZE_LSB = 4;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [1:0] SIZE_RESERVED = 2'h3;

  // ==========================================================
  // result kinds offered by the processor
  typedef enum logic [1:0] {
    RES_DATA = 2'h0,
    RES_COMPLETE = 2'h1,
    RES_BUS_ERROR = 2'h2,
    RES_ILLEGAL = 2'h3
  } bdsp_result_e;

  // ==========================================================
  // debug mode sequencer, one-hot
  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_HALT = 5'h02,
    ST_SERIAL = 5'h04,
    ST_EXIT_FREEZE = 5'h08,
    ST_EXIT_PINS = 5'h10
  } bdsp_mode_e;

  // ==========================================================
  // state records
  typedef struct packed {
    logic sampleBit;
    logic edgeToggle;
  } bdsp_link_s;

  typedef struct packed {
    bdsp_mode_e mode;
    logic togglePrev;
    logic [16:0] rxShift;
    logic [4:0] bitCount;
    logic advancePending;
    logic [16:0] txShift;
    logic pendValid;
    logic [16:0] pendWord;
    logic [15:0] rxLatch;
    logic rxStrobe;
    logic [5:0] opField;
    logic dirToHost;
    logic [1:0] sizeField;
    logic sizeReserved;
    logic [1:0] immWords;
    logic halted;
    logic flushPipe;
    logic fetchStart;
    logic breakpointReq;
    logic pipeOut;
    logic fetchOut;
    logic fetchOeN;
  } bdsp_core_s;

endpackage

`default_nettype wire

// *** hdl/bdsp_sync2.sv ***
/*
  Two-stage synchroniser for a small group of levels.
  Assumes each bit is a level that stays put for several destination clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module bdsp_sync2 #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } bdsp_sync_s;

  bdsp_sync_s syncReg;
  bdsp_sync_s syncNext;

  // ==========================================================
  // stage one feeds only stage two
  always_comb begin
    syncNext = syncReg;
    syncNext.stage1 = asyncIn;
    syncNext.stage2 = syncReg.stage1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncReg <= '0;
    end else if (clkEn) begin
      syncReg <= syncNext;
    end
  end

  assign syncOut = syncReg.stage2;

endmodule

`default_nettype wire

// *** hdl/bdsp_serial_port.sv ***
/*
  Device end of the background debug serial port: debug mode sequencer,
  17-bit full-duplex shifter, receive latch, response loading and
  command field decode.
  Assumes the host drives the serial clock on the shared breakpoint pin,
  at no more than half the core clock, idle high, and that the processor
  microcode consumes the receive latch and offers results.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - resume or call-user-code request leaves debug mode and restarts fetch.
// - halted drops first, then serial port off and pins revert.
// - in debug mode breakpoint pin clocks, fetch pin inputs, pipe pin outputs.
// - both sides shift together, MSB first, capture on rising edge.
// - every transfer is seventeen bits, status bit on top.
// - responses: 0/data, 0/FFFF complete, 1/0000, 1/0001, 1/FFFF.
// - serial clock and data are synchronised to the core clock.
// - on synced rising edge shift in, decrement count, then advance output.
// - a clock later at zero count latch word, load not-ready, release processor.
// - result replaces not-ready once no word is in flight; errors load an error response.
// - six-bit operation field selects among 64 commands.
// - direction bit set means device to host, clear means host to device.
// - size field: byte, word, long, reserved; addresses are 32-bit.
// - address takes two extension words; immediates one or two, MSW first.
// - second word answers not-ready or illegal; host then resends.
// - read results follow in two words; errors replace data.
// - entry suspends execution, asserts halted, then enables serial hardware.
module bdsp_serial_port (
  // core clock, reset and freeze
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // shared breakpoint / serial clock pin
  input wire logic debugSerialClock,
  // shared fetch status pin, serial data in while halted
  input wire logic fetchPinIn,
  output logic fetchPinOut,
  output logic fetchPinOeN,
  // shared pipe status pin, serial data out while halted
  output logic pipeStatusPin,
  // normal-mode status from the pipeline
  input wire logic fetchStatusIn,
  input wire logic pipeStatusIn,
  // debug mode control
  input wire logic enterDebug,
  input wire logic leaveDebug,
  output logic halted,
  output logic flushPipe,
  output logic fetchStart,
  output logic breakpointReq,
  // received word and decoded fields
  output logic [15:0] rxWord,
  output logic rxStrobe,
  output logic [5:0] opField,
  output logic dirToHost,
  output logic [1:0] sizeField,
  output logic sizeReserved,
  output logic [1:0] immWords,
  // result from the processor
  input wire logic resultLoad,
  input wire logic [1:0] resultKind,
  input wire logic [15:0] resultData
);

  // ==========================================================
  // link domain: capture on the host's rising clock edge
  bdsp_pkg::bdsp_link_s linkReg;
  bdsp_pkg::bdsp_link_s linkNext;

  // data bit and an edge toggle both change on the same edge
  always_comb begin
    linkNext = linkReg;
    linkNext.sampleBit = fetchPinIn;
    linkNext.edgeToggle = ~linkReg.edgeToggle;
  end

  // the link clock may stand still between words; nothing here needs it to run
  always_ff @(posedge debugSerialClock or negedge rst_n) begin
    if (!rst_n) begin
      linkReg <= '0;
    end else begin
      linkReg <= linkNext;
    end
  end

  // ==========================================================
  // crossing into the core clock
  logic [1:0] linkSync;
  logic pinLowSync;
  logic bitSync;
  logic toggleSync;

  // the bit holds a full link period, so it has settled when the toggle shows
  bdsp_sync2 #(
    .WIDTH(2)
  ) linkCross (
    .clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .asyncIn({linkReg.sampleBit, linkReg.edgeToggle}),
    .syncOut(linkSync)
  );

  // pin low level for breakpoint requests in normal mode; carried inverted so that
  // the cleared synchroniser means no request and no false request follows reset
  bdsp_sync2 #(
    .WIDTH(1)
  ) pinCross (
    .clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .asyncIn(~debugSerialClock),
    .syncOut(pinLowSync)
  );

  assign bitSync = linkSync[1];
  assign toggleSync = linkSync[0];

  // ==========================================================
  // core domain state
  bdsp_pkg::bdsp_core_s coreReg;
  bdsp_pkg::bdsp_core_s coreNext;
  logic risingSeen;
  logic wordIdle;
  logic [16:0] resultWord;
  logic serialPins;

  // in serial mode a new synced edge is any change of the crossed toggle
  assign risingSeen = (toggleSync != coreReg.togglePrev) && (coreReg.mode == bdsp_pkg::ST_SERIAL);

  // no word in flight: results may be written without tearing a transfer
  assign wordIdle = (coreReg.bitCount == bdsp_pkg::BIT_COUNT_FULL) && !coreReg.advancePending && !risingSeen;

  // map the processor's result onto the 17-bit response
  always_comb begin
    resultWord = bdsp_pkg::RESP_COMPLETE;
    case (bdsp_pkg::bdsp_result_e'(resultKind))
      bdsp_pkg::RES_DATA: begin
        resultWord = {1'b0, resultData};
      end
      bdsp_pkg::RES_COMPLETE: begin
        resultWord = bdsp_pkg::RESP_COMPLETE;
      end
      bdsp_pkg::RES_BUS_ERROR: begin
        resultWord = bdsp_pkg::RESP_BUS_ERROR;
      end
      bdsp_pkg::RES_ILLEGAL: begin
        resultWord = bdsp_pkg::RESP_ILLEGAL;
      end
      default: begin
        resultWord = bdsp_pkg::RESP_ILLEGAL;
      end
    endcase
  end

  // ==========================================================
  // sequencer, shifter and decode
  always_comb begin
    coreNext = coreReg;
    coreNext.rxStrobe = 1'b0;
    coreNext.flushPipe = 1'b0;
    coreNext.fetchStart = 1'b0;
    coreNext.togglePrev = toggleSync;
    serialPins = 1'b0;
    case (coreReg.mode)
      bdsp_pkg::ST_NORMAL: begin
        // pin is a plain breakpoint request while running
        coreNext.breakpointReq = pinLowSync;
        if (enterDebug) begin
          coreNext.mode = bdsp_pkg::ST_HALT;
          coreNext.halted = 1'b1;
          coreNext.breakpointReq = 1'b0;
        end
      end
      bdsp_pkg::ST_HALT: begin
        // serial hardware comes up only after halted is seen
        coreNext.mode = bdsp_pkg::ST_SERIAL;
        coreNext.txShift = bdsp_pkg::RESP_COMPLETE;
        coreNext.bitCount = bdsp_pkg::BIT_COUNT_FULL;
        coreNext.advancePending = 1'b0;
        coreNext.pendValid = 1'b0;
        serialPins = 1'b1;
      end
      bdsp_pkg::ST_SERIAL: begin
        serialPins = 1'b1;
        // capture edge: bit in, count down; status bit 16 is kept but unused
        if (risingSeen) begin
          coreNext.rxShift = {coreReg.rxShift[15:0], bitSync};
          coreNext.bitCount = coreReg.bitCount - 5'h01;
          coreNext.advancePending = 1'b1;
        end
        // one clock on: bring the next output bit up and check the count
        if (coreReg.advancePending) begin
          coreNext.advancePending = 1'b0;
          coreNext.txShift = {coreReg.txShift[15:0], 1'b0};
          if (coreReg.bitCount == bdsp_pkg::BIT_COUNT_DONE) begin
            coreNext.rxLatch = coreReg.rxShift[15:0];
            coreNext.rxStrobe = 1'b1;
            coreNext.txShift = bdsp_pkg::RESP_NOT_READY;
            coreNext.bitCount = bdsp_pkg::BIT_COUNT_FULL;
            coreNext.opField = coreReg.rxShift[bdsp_pkg::OP_MSB:bdsp_pkg::OP_LSB];
            coreNext.dirToHost = coreReg.rxShift[bdsp_pkg::DIR_POS];
            coreNext.sizeField = coreReg.rxShift[bdsp_pkg::SIZE_MSB:bdsp_pkg::SIZE_LSB];
            case (coreReg.rxShift[bdsp_pkg::SIZE_MSB:bdsp_pkg::SIZE_LSB])
              bdsp_pkg::SIZE_BYTE, bdsp_pkg::SIZE_WORD: begin
                coreNext.immWords = 2'h1;
                coreNext.sizeReserved = 1'b0;
              end
              bdsp_pkg::SIZE_LONG: begin
                coreNext.immWords = 2'h2;
                coreNext.sizeReserved = 1'b0;
              end
              default: begin
                coreNext.immWords = 2'h0;
                coreNext.sizeReserved = 1'b1;
              end
            endcase
          end
        end
        // results wait until no word is in flight, then overwrite not-ready
        if (coreReg.pendValid && wordIdle) begin
          coreNext.txShift = coreReg.pendWord;
          coreNext.pendValid = 1'b0;
        end
        // a new offer replaces an unsent one; the newest result wins
        if (resultLoad) begin
          coreNext.pendValid = 1'b1;
          coreNext.pendWord = resultWord;
        end
        if (leaveDebug) begin
          coreNext.mode = bdsp_pkg::ST_EXIT_FREEZE;
          coreNext.halted = 1'b0;
          coreNext.flushPipe = 1'b1;
          coreNext.pendValid = 1'b0;
        end
      end
      bdsp_pkg::ST_EXIT_FREEZE: begin
        // halted is already low; pins still serial for this one cycle
        serialPins = 1'b1;
        coreNext.mode = bdsp_pkg::ST_EXIT_PINS;
      end
      bdsp_pkg::ST_EXIT_PINS: begin
        // pins are back on pipeline status; fetch from the return address
        coreNext.mode = bdsp_pkg::ST_NORMAL;
        coreNext.fetchStart = 1'b1;
      end
      default: begin
        coreNext.mode = bdsp_pkg::ST_NORMAL;
        coreNext.halted = 1'b0;
      end
    endcase
    // shared pins follow the mode of the coming cycle
    if (serialPins && (coreNext.mode != bdsp_pkg::ST_EXIT_PINS)) begin
      coreNext.pipeOut = coreNext.txShift[bdsp_pkg::STATUS_POS];
      coreNext.fetchOut = 1'b0;
      coreNext.fetchOeN = 1'b1;
    end else begin
      coreNext.pipeOut = pipeStatusIn;
      coreNext.fetchOut = fetchStatusIn;
      coreNext.fetchOeN = 1'b0;
    end
  end

  // single register for all core state; clkEn low freezes it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      coreReg <= '{
        mode: bdsp_pkg::ST_NORMAL,
        bitCount: bdsp_pkg::BIT_COUNT_FULL,
        txShift: bdsp_pkg::RESP_COMPLETE,
        default: '0
      };
    end else if (clkEn) begin
      coreReg <= coreNext;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign fetchPinOut = coreReg.fetchOut;
  assign fetchPinOeN = coreReg.fetchOeN;
  assign pipeStatusPin = coreReg.pipeOut;
  assign halted = coreReg.halted;
  assign flushPipe = coreReg.flushPipe;
  assign fetchStart = coreReg.fetchStart;
  assign breakpointReq = coreReg.breakpointReq;
  assign rxWord = coreReg.rxLatch;
  assign rxStrobe = coreReg.rxStrobe;
  assign opField = coreReg.opField;
  assign dirToHost = coreReg.dirToHost;
  assign sizeField = coreReg.sizeField;
  assign sizeReserved = coreReg.sizeReserved;
  assign immWords = coreReg.immWords;

endmodule

`default_nettype wire

// *** test/bdsp_port_asserts.sv ***
/* port checker of the debug serial port, bound to the port module.
   assumes the core clock enable stays high. */
`timescale 1ns/1ps
`default_nettype none
// ==========
// checker
module bdsp_port_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // pins and mode
  input wire logic debugSerialClock,
  input wire logic fetchPinOeN,
  input wire logic pipeStatusPin,
  input wire logic enterDebug,
  input wire logic leaveDebug,
  input wire logic halted,
  input wire logic flushPipe,
  input wire logic fetchStart,
  input wire logic breakpointReq,
  // received word
  input wire logic [15:0] rxWord,
  input wire logic rxStrobe,
  input wire logic [5:0] opField,
  input wire logic dirToHost,
  input wire logic [1:0] sizeField,
  input wire logic sizeReserved,
  input wire logic [1:0] immWords,
  // results
  input wire logic resultLoad,
  input wire logic [1:0] resultKind
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic wordIdle_reg;
  // a result only loads at once between words; mid-word it waits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) wordIdle_reg <= 1'b1;
    else if (rxStrobe) wordIdle_reg <= 1'b1;
    else if (!debugSerialClock) wordIdle_reg <= 1'b0;
  end
  a_op_decode: assert property (rxStrobe |-> opField == rxWord[15:10] && dirToHost == rxWord[7])
    else $error("command field decode wrong");
  a_size_decode: assert property (rxStrobe |-> sizeField == rxWord[5:4] && sizeReserved == (rxWord[5:4] == 2'h3))
    else $error("size decode wrong");
  a_imm_count: assert property (rxStrobe |-> immWords == (rxWord[5:4] == 2'h3 ? 2'h0 : (rxWord[5] ? 2'h2 : 2'h1)))
    else $error("extension word count wrong");
  a_word_notready: assert property (rxStrobe |-> pipeStatusPin && halted)
    else $error("no not-ready status after word");
  a_result_load: assert property (resultLoad && wordIdle_reg && halted && debugSerialClock
    |-> ##2 pipeStatusPin == $past(resultKind[1], 2)) else $error("result status wrong");
  a_enter_seq: assert property (enterDebug && !halted && !fetchPinOeN && !$past(halted, 3)
    |=> halted ##1 fetchPinOeN && !pipeStatusPin) else $error("debug entry order wrong");
  a_leave_seq: assert property (leaveDebug && halted && fetchPinOeN
    |=> !halted && flushPipe && fetchPinOeN ##1 !fetchPinOeN ##1 fetchStart) else $error("debug exit order wrong");
  a_break_req: assert property ((!debugSerialClock && !halted && !fetchPinOeN) [*5] |-> breakpointReq)
    else $error("breakpoint request missed");
endmodule
`default_nettype wire
bind bdsp_serial_port bdsp_port_checker i_chk (.core_clk(core_clk), .rst_n(rst_n),
  .debugSerialClock(debugSerialClock), .fetchPinOeN(fetchPinOeN), .pipeStatusPin(pipeStatusPin),
  .enterDebug(enterDebug), .leaveDebug(leaveDebug), .halted(halted), .flushPipe(flushPipe),
  .fetchStart(fetchStart), .breakpointReq(breakpointReq), .rxWord(rxWord), .rxStrobe(rxStrobe),
  .opField(opField), .dirToHost(dirToHost), .sizeField(sizeField), .sizeReserved(sizeReserved),
  .immWords(immWords), .resultLoad(resultLoad), .resultKind(resultKind));

// *** test/bdsp_host_model.sv ***
/* host end of the debug link: clock master, word shifter, entry latch.
   assumes the bench pulses go and waits for busy to drop. */
`timescale 1ns/1ps
`default_nettype none
// ==========
// host model
module bdsp_host_model (
  // transfer control
  input wire logic go,
  input wire logic slow,
  input wire logic forceEntry,
  input wire logic [16:0] txWord,
  output logic [16:0] rxWord,
  output logic busy,
  // link pins
  output logic debugSerialClock,
  output logic fetchPinData,
  input wire logic pipeStatusPin
);
  logic linkClk = 1'b0;
  logic sclk = 1'b1;
  logic entryLatch = 1'b0;
  int i;
  int k;
  // free 48 ns base, phase unrelated to the core clock
  initial begin
    #7;
    forever #24 linkClk = ~linkClk;
  end
  assign debugSerialClock = sclk & ~entryLatch;
  // set-reset latch holds the pin low until the first shift clock falls
  always @(posedge forceEntry or negedge sclk) entryLatch = forceEntry;
  // one 17-bit word per go; long high phase keeps the rate under half the core clock
  initial begin
    busy = 1'b0;
    rxWord = 17'h00000;
    fetchPinData = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      for (i = 16; i >= 0; i--) begin
        @(negedge linkClk);
        sclk = 1'b0;
        #1 fetchPinData = txWord[i];
        @(posedge linkClk);
        sclk = 1'b1;
        rxWord[i] = pipeStatusPin;
        for (k = 0; k < (slow ? 6 : 3); k++) @(posedge linkClk);
      end
      fetchPinData = ~fetchPinData; // last bit is inverted so the line shows no stale value
      busy = 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** test/bdsp_serial_port_test.sv ***
/* bench of the debug serial port: the main sequence plays the processor, the host
   model plays the link master. assumes the package is compiled first. */
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench top
module bdsp_serial_port_test;
  logic coreClk = 1'b0;
  logic rstN = 1'b0;
  logic clkEn = 1'b1;
  logic fetchStatusIn = 1'b0;
  logic pipeStatusIn = 1'b0;
  logic enterDebug = 1'b0;
  logic leaveDebug = 1'b0;
  logic resultLoad = 1'b0;
  logic [1:0] resultKind = 2'h0;
  logic [15:0] resultData = 16'h0000;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic forceEntry = 1'b0;
  logic [16:0] txWord = 17'h00000;
  logic [16:0] hostRx, expRx;
  logic busy, sclkPin, hostData, fetchWire, fetchPinOut, fetchPinOeN, pipeStatusPin, halted;
  logic flushPipe, fetchStart, breakpointReq, rxStrobe, dirToHost, sizeReserved;
  logic [15:0] rxWord;
  logic [5:0] opField;
  logic [1:0] sizeField, immWords;
  int bad_count = 0;
  int n_compared = 0;
  int strobes = 0;
  int i;
  logic [16:0] cmdTab [6] = '{17'h0FC80, 17'h00010, 17'h0A4A0, 17'h05430, 17'h02345, 17'h00000};
  logic [2:0] kindTab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0}; // 4: nothing offered
  always #12.5 coreClk = ~coreClk;
  // shared fetch pin: device drives while its enable is low
  assign fetchWire = fetchPinOeN ? hostData : fetchPinOut;
  always @(posedge coreClk) begin
    if (rxStrobe === 1'b1) strobes <= strobes + 1;
  end
  bdsp_serial_port i_dut (.core_clk(coreClk), .rst_n(rstN), .clkEn(clkEn), .debugSerialClock(sclkPin),
    .fetchPinIn(fetchWire), .fetchPinOut(fetchPinOut), .fetchPinOeN(fetchPinOeN), .pipeStatusPin(pipeStatusPin),
    .fetchStatusIn(fetchStatusIn), .pipeStatusIn(pipeStatusIn), .enterDebug(enterDebug), .leaveDebug(leaveDebug),
    .halted(halted), .flushPipe(flushPipe), .fetchStart(fetchStart), .breakpointReq(breakpointReq),
    .rxWord(rxWord), .rxStrobe(rxStrobe), .opField(opField), .dirToHost(dirToHost), .sizeField(sizeField),
    .sizeReserved(sizeReserved), .immWords(immWords), .resultLoad(resultLoad), .resultKind(resultKind),
    .resultData(resultData));
  bdsp_host_model i_host (.go(go), .slow(slow), .forceEntry(forceEntry), .txWord(txWord), .rxWord(hostRx),
    .busy(busy), .debugSerialClock(sclkPin), .fetchPinData(hostData), .pipeStatusPin(pipeStatusPin));
  // expected reply word for a result kind
  function automatic logic [16:0] resp_of(input logic [2:0] kind, input logic [15:0] data);
    case (kind)
      3'h0: resp_of = {1'b0, data};
      3'h1: resp_of = bdsp_pkg::RESP_COMPLETE;
      3'h2: resp_of = bdsp_pkg::RESP_BUS_ERROR;
      3'h3: resp_of = bdsp_pkg::RESP_ILLEGAL;
      default: resp_of = bdsp_pkg::RESP_NOT_READY;
    endcase
  endfunction
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one word over the link; bounded wait on the host
  task automatic send(input logic [16:0] w);
    int k;
    @(posedge coreClk);
    txWord <= w;
    go <= 1'b1;
    @(posedge coreClk);
    go <= 1'b0;
    for (k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge coreClk);
    check("link_idle", 17'(busy), 17'h0);
    if (busy !== 1'b0) finish_test();
    repeat (2) @(posedge coreClk);
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (5) @(posedge coreClk);
    rstN <= 1'b1;
    pipeStatusIn <= 1'b1;
    fetchStatusIn <= 1'b1;
    repeat (2) @(negedge coreClk);
    check("pipe_pin", 17'(pipeStatusPin), 17'h1);
    check("fetch_pin", 17'(fetchPinOut), 17'h1);
    check("break_idle", 17'(breakpointReq), 17'h0);
    @(posedge coreClk);
    forceEntry <= 1'b1;
    @(posedge coreClk);
    forceEntry <= 1'b0;
    for (i = 0; i < 10 && breakpointReq !== 1'b1; i++) @(negedge coreClk);
    check("break_req", 17'(breakpointReq), 17'h1);
    @(posedge coreClk);
    enterDebug <= 1'b1;
    @(posedge coreClk);
    enterDebug <= 1'b0;
    @(posedge coreClk);
    @(negedge coreClk);
    check("halted", 17'(halted), 17'h1);
    @(negedge coreClk);
    check("fetch_oe_n", 17'(fetchPinOeN), 17'h1);
    $display("test entry done");
    expRx = bdsp_pkg::RESP_COMPLETE;
    for (i = 0; i < 6; i++) begin
      slow <= (i == 4);
      send(cmdTab[i]);
      @(negedge coreClk);
      check("host_rx", hostRx, expRx);
      check("rx_word", 17'(rxWord), 17'(cmdTab[i][15:0]));
      check("op_field", 17'(opField), 17'(cmdTab[i][15:10]));
      check("dir_bit", 17'(dirToHost), 17'(cmdTab[i][7]));
      check("size", {14'h0, sizeReserved, sizeField}, {14'h0, cmdTab[i][5:4] == 2'h3, cmdTab[i][5:4]});
      check("imm", 17'(immWords), 17'(cmdTab[i][5:4] == 2'h3 ? 2'h0 : (cmdTab[i][5] ? 2'h2 : 2'h1)));
      check("strobes", 17'(strobes), 17'(i + 1));
      check("not_ready", 17'(pipeStatusPin), 17'h1);
      expRx = resp_of(kindTab[i], 16'h8001 + 16'(i));
      if (kindTab[i] != 3'h4) begin
        @(posedge coreClk);
        resultLoad <= 1'b1;
        resultKind <= kindTab[i][1:0];
        resultData <= 16'h8001 + 16'(i);
        @(posedge coreClk);
        resultLoad <= 1'b0;
        repeat (3) @(posedge coreClk);
      end
      $display("test word %0d done", i);
    end
    @(posedge coreClk);
    leaveDebug <= 1'b1;
    @(posedge coreClk);
    leaveDebug <= 1'b0;
    @(negedge coreClk);
    check("halted", 17'(halted), 17'h0);
    check("flush", 17'(flushPipe), 17'h1);
    check("oe_hold", 17'(fetchPinOeN), 17'h1);
    @(negedge coreClk);
    check("fetch_oe_n", 17'(fetchPinOeN), 17'h0);
    @(negedge coreClk);
    check("fetch_start", 17'(fetchStart), 17'h1);
    $display("test leave done");
    finish_test();
  end
endmodule
`default_nettype wire
